// >>> src/uls_line_modem_status.sv
// Behaviour
// - Data ready set while receive data held.
// - Non-FIFO overrun overwrites unread old character.
// - FIFO overrun only when full; character dropped.
// - Overrun flag immediate, cleared by status read.
// - Parity mismatch sets bit two, read clears.
// - Low stop bit sets framing bit three.
// - FIFO errors travel with characters, shown at head.
// - After framing error without break, low stop restarts start.
// - Long low line sets break bit four.
// - Break stores one zero character, waits half-bit high.
// - Bits one to four raise line interrupt.
// - Holding empty set on shift load, cleared by write.
// - FIFO mode holding empty follows transmit FIFO.
// - Holding empty drives enabled transmit interrupt.
// - Transmitter idle only when holding and shifter empty.
// - Bit seven shows stored FIFO errors, zero otherwise.
// - Modem deltas set on change, read clears all.
// - Ring delta records only trailing ring edge.
// - Any modem delta raises modem interrupt.
// - Upper modem bits show inverted input levels.
// - Loopback shows modem control bits in upper bits.
// - Loopback routes transmit and control outputs inside.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module uls_line_modem_status
	import uls_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input  wire logic       sys_clk_in,          // System clock, 40 MHz
	input  wire logic       rst_n_in,            // Synchronous reset, low
	input  wire logic       baud16_tick_in,      // Sixteen times baud tick
	input  wire logic [2:0] reg_addr_in,         // Register offset
	input  wire logic [7:0] reg_wdata_in,        // Write data
	input  wire logic       reg_wr_in,           // Write strobe
	input  wire logic       reg_rd_in,           // Read strobe
	output logic      [7:0] reg_rdata_out,       // Read data, next cycle
	input  wire logic       rx_serial_in,        // Serial receive pin
	output logic            tx_serial_out,       // Serial transmit pin
	input  wire logic       clear_to_send_n_in,  // Clear to send, low
	input  wire logic       set_ready_n_in,      // Data set ready, low
	input  wire logic       ring_in_n_in,        // Ring indicator, low
	input  wire logic       carrier_detect_n_in, // Carrier detect, low
	output logic            request_send_n_out,  // Request to send, low
	output logic            term_ready_n_out,    // Terminal ready, low
	output logic            line_irq_out,        // Line status interrupt
	output logic            tx_irq_out,          // Holding empty interrupt
	output logic            modem_irq_out        // Modem status interrupt
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;

	function automatic logic hit(input logic strobe, input logic [2:0] addr,
			input logic [2:0] off);
		hit = strobe && (addr == off);
	endfunction : hit

	function automatic logic [3:0] word_len(input logic [7:0] lc);
		word_len = {2'b00, lc[1:0]} + WLEN_BASE;
	endfunction : word_len

	// Start bit, data, optional parity, then stop bits left at one.
	function automatic logic [FRAME_W-1:0] build_frame(input logic [7:0] d,
			input logic [7:0] lc);
		logic [FRAME_W-1:0] f;
		logic [3:0]         wl;
		logic [7:0]         m;
		logic               p;
		wl   = word_len(lc);
		m    = 8'h00;
		f    = '1;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(wl)) begin
				m[i]     = d[i];
				f[i + 1] = d[i];
			end
		end
		if (lc[LC_STICK])
			p = ~lc[LC_EVEN];
		else if (lc[LC_EVEN])
			p = ^m;
		else
			p = ~^m;
		if (lc[LC_PAR_EN])
			f[wl + 4'h1] = p;
		build_frame = f;
	endfunction : build_frame

	logic [7:0]         irq_en_q;
	logic [7:0]         line_ctl_q;
	logic [7:0]         modem_ctl_q;
	logic               fifo_en_q;
	logic               rx_meta_q;
	logic               rx_sync_q;
	logic [3:0]         modem_meta_q;
	logic [3:0]         modem_sync_q;
	uls_rx_state_t      rx_state_q;
	logic [3:0]         rx_tick_q;
	logic [2:0]         rx_bit_q;
	logic [7:0]         rx_shift_q;
	logic               rx_zero_q;
	logic               rx_ones_q;
	logic               rx_perr_q;
	logic               rx_push_q;
	logic [7:0]         rx_word_q;
	logic [2:0]         rx_err_q;
	logic [10:0]        rx_mem [DEPTH];
	logic [PTR_W-1:0]   rx_wr_q;
	logic [PTR_W-1:0]   rx_rd_q;
	logic [CNT_W-1:0]   rx_cnt_q;
	logic [CNT_W-1:0]   rx_err_cnt_q;
	logic               overrun_q;
	logic [2:0]         sticky_err_q;
	logic [7:0]         tx_mem [DEPTH];
	logic [PTR_W-1:0]   tx_wr_q;
	logic [PTR_W-1:0]   tx_rd_q;
	logic [CNT_W-1:0]   tx_cnt_q;
	logic               tx_busy_q;
	logic [3:0]         tx_tick_q;
	logic [3:0]         tx_left_q;
	logic [FRAME_W-1:0] tx_sh_q;
	logic [3:0]         modem_prev_q;
	logic [3:0]         delta_q;
	logic [7:0]         reg_rdata_q;

	logic               loop;
	logic               rx_line;
	logic               tx_line;
	logic               rx_clr;
	logic               tx_clr;
	logic [CNT_W-1:0]   cap;
	logic               rx_pop;
	logic               rx_full;
	logic               rx_ok;
	logic               rx_ovr;
	logic [10:0]        rx_head;
	logic               tx_push;
	logic               tx_load;
	logic               tx_holding_empty;
	logic               tx_all_idle;
	logic [3:0]         modem_act;
	logic [3:0]         delta_set;
	logic [2:0]         shown_err;
	logic [7:0]         line_state;
	logic [7:0]         modem_state;
	logic               ls_rd;
	logic               ms_rd;

	assign loop    = modem_ctl_q[MC_LOOP];
	assign ls_rd   = hit(reg_rd_in, reg_addr_in, OFF_LINE_STATE);
	assign ms_rd   = hit(reg_rd_in, reg_addr_in, OFF_MODEM_STATE);
	assign cap     = fifo_en_q ? CNT_W'(DEPTH) : CNT_W'(1);
	assign tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;
	assign rx_line = loop ? tx_line : rx_sync_q;

	// A change of FIFO mode discards both queues so no stale entries leak.
	always_comb begin
		rx_clr = 1'b0;
		tx_clr = 1'b0;
		if (hit(reg_wr_in, reg_addr_in, OFF_FIFO_CTL)) begin
			rx_clr = reg_wdata_in[FC_RX_CLR] ||
				(reg_wdata_in[FC_EN] != fifo_en_q);
			tx_clr = reg_wdata_in[FC_TX_CLR] ||
				(reg_wdata_in[FC_EN] != fifo_en_q);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			irq_en_q    <= IRQ_EN_RST;
			line_ctl_q  <= LINE_CTL_RST;
			modem_ctl_q <= MODEM_CTL_RST;
			fifo_en_q   <= 1'b0;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				OFF_IRQ_EN:    irq_en_q    <= reg_wdata_in & IRQ_EN_MASK;
				OFF_LINE_CTL:  line_ctl_q  <= reg_wdata_in;
				OFF_MODEM_CTL: modem_ctl_q <= reg_wdata_in & MODEM_CTL_MSK;
				OFF_FIFO_CTL:  fifo_en_q   <= reg_wdata_in[FC_EN];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rx_meta_q    <= 1'b1;
			rx_sync_q    <= 1'b1;
			modem_meta_q <= '1;
			modem_sync_q <= '1;
		end else begin
			rx_meta_q    <= rx_serial_in;
			rx_sync_q    <= rx_meta_q;
			modem_meta_q <= {carrier_detect_n_in, ring_in_n_in,
				set_ready_n_in, clear_to_send_n_in};
			modem_sync_q <= modem_meta_q;
		end
	end

	// Receiver; a character is handed on as a one-cycle push.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rx_state_q <= RX_IDLE;
			rx_tick_q  <= '0;
			rx_bit_q   <= '0;
			rx_shift_q <= '0;
			rx_zero_q  <= 1'b0;
			rx_ones_q  <= 1'b0;
			rx_perr_q  <= 1'b0;
			rx_push_q  <= 1'b0;
			rx_word_q  <= '0;
			rx_err_q   <= '0;
		end else begin
			rx_push_q <= 1'b0;
			if (baud16_tick_in) begin
				rx_tick_q <= rx_tick_q + 4'h1;
				case (rx_state_q)
					RX_IDLE: begin
						rx_tick_q <= '0;
						if (!rx_line)
							rx_state_q <= RX_START;
					end
					RX_START: begin
						if (rx_tick_q == TICK_HALF) begin
							rx_tick_q  <= '0;
							rx_bit_q   <= '0;
							rx_shift_q <= '0;
							rx_zero_q  <= 1'b1;
							rx_ones_q  <= 1'b0;
							rx_perr_q  <= 1'b0;
							rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rx_tick_q == TICK_LAST) begin
							rx_shift_q[rx_bit_q] <= rx_line;
							rx_zero_q <= rx_zero_q & ~rx_line;
							rx_ones_q <= rx_ones_q ^ rx_line;
							rx_bit_q  <= rx_bit_q + 3'h1;
							if ({1'b0, rx_bit_q} + 4'h1 == word_len(line_ctl_q))
								rx_state_q <= line_ctl_q[LC_PAR_EN] ?
									RX_PAR : RX_STOP;
						end
					end
					RX_PAR: begin
						if (rx_tick_q == TICK_LAST) begin
							rx_zero_q <= rx_zero_q & ~rx_line;
							if (line_ctl_q[LC_STICK])
								rx_perr_q <= rx_line == line_ctl_q[LC_EVEN];
							else
								rx_perr_q <= (rx_ones_q ^ rx_line) ==
									line_ctl_q[LC_EVEN];
							rx_state_q <= RX_STOP;
						end
					end
					RX_STOP: begin
						if (rx_tick_q == TICK_LAST) begin
							rx_push_q          <= 1'b1;
							rx_tick_q          <= '0;
							rx_err_q[ERR_PE]   <= rx_perr_q;
							rx_err_q[ERR_FE]   <= ~rx_line;
							rx_err_q[ERR_BI]   <= ~rx_line & rx_zero_q;
							rx_word_q <= (~rx_line & rx_zero_q) ? 8'h00 :
								rx_shift_q;
							if (!rx_line && rx_zero_q)
								rx_state_q <= RX_BRK;
							else if (!rx_line) begin
								// The low stop was seen at mid-bit, so one more
								// start sample keeps the data samples centred.
								rx_tick_q  <= TICK_HALF;
								rx_state_q <= RX_START;
							end else
								rx_state_q <= RX_IDLE;
						end
					end
					RX_BRK: begin
						// Only a half bit of steady mark ends the break.
						if (!rx_line)
							rx_tick_q <= '0;
						else if (rx_tick_q == TICK_HALF)
							rx_state_q <= RX_IDLE;
					end
					default: rx_state_q <= RX_IDLE;
				endcase
			end
		end
	end

	// Non-FIFO mode is the same queue with room for one character.
	assign rx_pop  = hit(reg_rd_in, reg_addr_in, OFF_DATA) && (rx_cnt_q != '0);
	assign rx_full = (rx_cnt_q >= cap) && !rx_pop;
	assign rx_ok   = rx_push_q && !rx_full;
	assign rx_ovr  = rx_push_q && rx_full;
	assign rx_head = rx_mem[rx_rd_q];

	always_ff @(posedge sys_clk_in) begin
		if (rx_ok)
			rx_mem[rx_wr_q] <= {rx_err_q, rx_word_q};
		else if (rx_ovr && !fifo_en_q)
			rx_mem[rx_rd_q] <= {rx_err_q, rx_word_q};
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || rx_clr) begin
			rx_wr_q      <= '0;
			rx_rd_q      <= '0;
			rx_cnt_q     <= '0;
			rx_err_cnt_q <= '0;
		end else begin
			if (rx_ok)
				rx_wr_q <= rx_wr_q + 1'b1;
			if (rx_pop)
				rx_rd_q <= rx_rd_q + 1'b1;
			rx_cnt_q <= rx_cnt_q + CNT_W'(rx_ok) - CNT_W'(rx_pop);
			rx_err_cnt_q <= rx_err_cnt_q + CNT_W'(rx_ok && (rx_err_q != '0))
				- CNT_W'(rx_pop && (rx_head[10:8] != '0));
		end
	end

	// New events win over the clearing read of the same cycle.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			overrun_q    <= 1'b0;
			sticky_err_q <= '0;
		end else begin
			overrun_q <= rx_ovr || (overrun_q && !ls_rd);
			sticky_err_q <= ((rx_push_q && !fifo_en_q) ? rx_err_q : 3'h0) |
				(sticky_err_q & ~{3{ls_rd}});
		end
	end

	// Transmit queue and shifter.
	assign tx_push = hit(reg_wr_in, reg_addr_in, OFF_DATA) && (tx_cnt_q < cap);
	assign tx_load = !tx_busy_q && (tx_cnt_q != '0);
	assign tx_holding_empty    = (tx_cnt_q == '0);
	assign tx_all_idle    = tx_holding_empty && !tx_busy_q;

	always_ff @(posedge sys_clk_in) begin
		if (tx_push)
			tx_mem[tx_wr_q] <= reg_wdata_in;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || tx_clr) begin
			tx_wr_q  <= '0;
			tx_rd_q  <= '0;
			tx_cnt_q <= '0;
		end else begin
			if (tx_push)
				tx_wr_q <= tx_wr_q + 1'b1;
			if (tx_load)
				tx_rd_q <= tx_rd_q + 1'b1;
			tx_cnt_q <= tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_load);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			tx_busy_q <= 1'b0;
			tx_tick_q <= '0;
			tx_left_q <= '0;
			tx_sh_q   <= '1;
		end else if (tx_load) begin
			tx_busy_q <= 1'b1;
			tx_tick_q <= '0;
			tx_sh_q   <= build_frame(tx_mem[tx_rd_q], line_ctl_q);
			tx_left_q <= FRAME_MIN + word_len(line_ctl_q) +
				{3'b000, line_ctl_q[LC_PAR_EN]} +
				{3'b000, line_ctl_q[LC_STOP2]};
		end else if (tx_busy_q && baud16_tick_in) begin
			tx_tick_q <= tx_tick_q + 4'h1;
			if (tx_tick_q == TICK_LAST) begin
				tx_sh_q   <= {1'b1, tx_sh_q[FRAME_W-1:1]};
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_left_q == 4'h1)
					tx_busy_q <= 1'b0;
			end
		end
	end

	// Modem inputs as active-high levels, ordered cts, dsr, ri, dcd.
	assign modem_act = loop ? {modem_ctl_q[MC_IRQ_GATE_OUT], modem_ctl_q[MC_USER_OUT_A],
		modem_ctl_q[MC_DTR], modem_ctl_q[MC_RTS]} :
		~modem_sync_q;
	assign delta_set = {modem_act[3] ^ modem_prev_q[3],
		modem_prev_q[2] & ~modem_act[2],
		modem_act[1] ^ modem_prev_q[1],
		modem_act[0] ^ modem_prev_q[0]};

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			modem_prev_q <= '0;
			delta_q      <= '0;
		end else begin
			modem_prev_q <= modem_act;
			delta_q <= delta_set | (delta_q & ~{4{ms_rd}});
		end
	end

	assign shown_err = fifo_en_q ? (rx_head[10:8] & {3{rx_cnt_q != '0}}) :
		sticky_err_q;

	always_comb begin
		line_state          = 8'h00;
		line_state[LS_DR]   = (rx_cnt_q != '0);
		line_state[LS_OE]   = overrun_q;
		line_state[LS_PE]   = shown_err[ERR_PE];
		line_state[LS_FE]   = shown_err[ERR_FE];
		line_state[LS_BI]   = shown_err[ERR_BI];
		line_state[LS_TX_HOLDING_EMPTY] = tx_holding_empty;
		line_state[LS_TX_ALL_IDLE] = tx_all_idle;
		line_state[LS_FERR] = fifo_en_q && (rx_err_cnt_q != '0);
	end

	assign modem_state = {modem_act, delta_q};

	// Read data are captured before the same edge clears read flags.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || !reg_rd_in) begin
			reg_rdata_q <= 8'h00;
		end else begin
			case (reg_addr_in)
				OFF_DATA:        reg_rdata_q <= rx_head[7:0];
				OFF_IRQ_EN:      reg_rdata_q <= irq_en_q;
				OFF_LINE_CTL:    reg_rdata_q <= line_ctl_q;
				OFF_MODEM_CTL:   reg_rdata_q <= modem_ctl_q;
				OFF_LINE_STATE:  reg_rdata_q <= line_state;
				OFF_MODEM_STATE: reg_rdata_q <= modem_state;
				default:         reg_rdata_q <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			tx_serial_out      <= 1'b1;
			request_send_n_out <= 1'b1;
			term_ready_n_out   <= 1'b1;
			line_irq_out       <= 1'b0;
			tx_irq_out         <= 1'b0;
			modem_irq_out      <= 1'b0;
		end else begin
			tx_serial_out <= loop ||
				(tx_line && !line_ctl_q[LC_BREAK]);
			request_send_n_out <= loop || !modem_ctl_q[MC_RTS];
			term_ready_n_out   <= loop || !modem_ctl_q[MC_DTR];
			line_irq_out <= irq_en_q[IE_LINE] &&
				(line_state[LS_BI:LS_OE] != '0);
			tx_irq_out    <= irq_en_q[IE_TX] && tx_holding_empty;
			modem_irq_out <= irq_en_q[IE_MODEM] && (delta_q != '0);
		end
	end

	assign reg_rdata_out = reg_rdata_q;

endmodule : uls_line_modem_status

// >>> src/uls_pkg.sv
package uls_pkg;

	// Register offsets on the host port.
	localparam logic [2:0] OFF_DATA        = 3'h0;
	localparam logic [2:0] OFF_IRQ_EN      = 3'h1;
	localparam logic [2:0] OFF_FIFO_CTL    = 3'h2;
	localparam logic [2:0] OFF_LINE_CTL    = 3'h3;
	localparam logic [2:0] OFF_MODEM_CTL   = 3'h4;
	localparam logic [2:0] OFF_LINE_STATE  = 3'h5;
	localparam logic [2:0] OFF_MODEM_STATE = 3'h6;

	// Reset values and writable masks.
	localparam logic [7:0] IRQ_EN_RST    = 8'h00;
	localparam logic [7:0] IRQ_EN_MASK   = 8'h0F;
	localparam logic [7:0] LINE_CTL_RST  = 8'h00;
	localparam logic [7:0] MODEM_CTL_RST = 8'h00;
	localparam logic [7:0] MODEM_CTL_MSK = 8'h1F;

	// Line state flag positions.
	localparam int LS_DR   = 0;
	localparam int LS_OE   = 1;
	localparam int LS_PE   = 2;
	localparam int LS_FE   = 3;
	localparam int LS_BI   = 4;
	localparam int LS_TX_HOLDING_EMPTY = 5;
	localparam int LS_TX_ALL_IDLE = 6;
	localparam int LS_FERR = 7;

	// Modem line flag positions; current levels start at MS_LEVEL.
	localparam int MS_LEVEL = 4;

	// Line control fields.
	localparam int LC_STOP2  = 2;
	localparam int LC_PAR_EN = 3;
	localparam int LC_EVEN   = 4;
	localparam int LC_STICK  = 5;
	localparam int LC_BREAK  = 6;

	// Modem control fields.
	localparam int MC_DTR  = 0;
	localparam int MC_RTS  = 1;
	localparam int MC_USER_OUT_A = 2;
	localparam int MC_IRQ_GATE_OUT = 3;
	localparam int MC_LOOP = 4;

	// Interrupt enable and FIFO control fields.
	localparam int IE_TX    = 1;
	localparam int IE_LINE  = 2;
	localparam int IE_MODEM = 3;
	localparam int FC_EN     = 0;
	localparam int FC_RX_CLR = 1;
	localparam int FC_TX_CLR = 2;

	// Error field inside a stored receive entry.
	localparam int ERR_PE = 0;
	localparam int ERR_FE = 1;
	localparam int ERR_BI = 2;

	// Sixteen baud ticks per bit; the middle is sampled.
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_HALF = 4'h7;
	localparam logic [3:0] WLEN_BASE = 4'h5;
	localparam logic [3:0] FRAME_MIN = 4'h2;
	localparam int         FRAME_W   = 12;

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_PAR,
		RX_STOP,
		RX_BRK
	} uls_rx_state_t;

endpackage : uls_pkg

// >>> test/uls_line_modem_status_sva.sv
`timescale 1ns/1ps
module uls_status_chk
	import uls_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic       sys_clk_in,          // clock
	input wire logic       rst_n_in,            // reset, low
	input wire logic       baud16_tick_in,      // baud tick
	input wire logic [2:0] reg_addr_in,         // offset
	input wire logic [7:0] reg_wdata_in,        // write data
	input wire logic       reg_wr_in,           // write strobe
	input wire logic       reg_rd_in,           // read strobe
	input wire logic [7:0] reg_rdata_out,       // read data
	input wire logic       rx_serial_in,        // serial in
	input wire logic       tx_serial_out,       // serial out
	input wire logic       clear_to_send_n_in,  // modem in
	input wire logic       set_ready_n_in,      // modem in
	input wire logic       ring_in_n_in,        // modem in
	input wire logic       carrier_detect_n_in, // modem in
	input wire logic       request_send_n_out,  // modem out
	input wire logic       term_ready_n_out,    // modem out
	input wire logic       line_irq_out,        // interrupt
	input wire logic       tx_irq_out,          // interrupt
	input wire logic       modem_irq_out        // interrupt
);
	logic [7:0] mcr_q;
	logic [7:0] ier_q;
	logic [3:0] pins_q;
	logic [3:0] quiet_q;
	logic [3:0] pins;
	logic       rd_ls;
	logic       rd_ms;
	logic       mcr_wr;

	assign pins = {carrier_detect_n_in, ring_in_n_in, set_ready_n_in,
		clear_to_send_n_in};
	assign rd_ls = reg_rd_in && reg_addr_in == OFF_LINE_STATE;
	assign rd_ms = reg_rd_in && reg_addr_in == OFF_MODEM_STATE;
	assign mcr_wr = reg_wr_in && reg_addr_in == OFF_MODEM_CTL;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			mcr_q <= 8'h00;
			ier_q <= 8'h00;
		end else if (mcr_wr) begin
			mcr_q <= reg_wdata_in & MODEM_CTL_MSK;
		end else if (reg_wr_in && reg_addr_in == OFF_IRQ_EN) begin
			ier_q <= reg_wdata_in & IRQ_EN_MASK;
		end
	end

	// Counts cycles since modem pins or control last moved, so level checks
	// wait out the input synchronisers.
	always_ff @(posedge sys_clk_in) begin
		pins_q <= pins;
		if (!rst_n_in || pins != pins_q || mcr_wr)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hF)
			quiet_q <= quiet_q + 4'h1;
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data not zero outside a read");
	a_tx_all_idle_tx_holding_empty: assert property ($past(rd_ls) && reg_rdata_out[LS_TX_ALL_IDLE] |-> reg_rdata_out[LS_TX_HOLDING_EMPTY])
		else $error("transmitter idle while holding not empty");
	a_msr_level: assert property ($past(rd_ms) && !mcr_q[MC_LOOP] && quiet_q > 4'h3 |-> reg_rdata_out[7:4] == ~pins)
		else $error("modem levels not inverted inputs");
	a_msr_loop: assert property ($past(rd_ms) && mcr_q[MC_LOOP] && quiet_q > 4'h3 |-> reg_rdata_out[7:4] == {mcr_q[MC_IRQ_GATE_OUT], mcr_q[MC_USER_OUT_A], mcr_q[MC_DTR], mcr_q[MC_RTS]})
		else $error("loopback modem levels wrong");
	a_ctl_pins: assert property (quiet_q > 4'h1 |-> request_send_n_out == (mcr_q[MC_LOOP] | ~mcr_q[MC_RTS]) && term_ready_n_out == (mcr_q[MC_LOOP] | ~mcr_q[MC_DTR]))
		else $error("modem control outputs wrong");
	a_tx_loop_mark: assert property (mcr_q[MC_LOOP] && quiet_q > 4'h1 |-> tx_serial_out)
		else $error("serial out not marking in loopback");
	a_modem_irq: assert property ($past(rd_ms) && $past(ier_q[IE_MODEM]) && |reg_rdata_out[3:0] |-> modem_irq_out)
		else $error("modem interrupt missing");
	a_irq_gated: assert property (!$past(ier_q[IE_MODEM]) |-> !modem_irq_out)
		else $error("modem interrupt while disabled");
	a_line_irq: assert property ($past(rd_ls) && $past(ier_q[IE_LINE]) && |reg_rdata_out[4:1] |-> line_irq_out)
		else $error("line interrupt missing");
	a_tx_irq: assert property ($past(rd_ls) && $past(ier_q[IE_TX]) && reg_rdata_out[LS_TX_HOLDING_EMPTY] |-> tx_irq_out)
		else $error("transmit interrupt missing");

	c_overrun: cover property ($past(rd_ls) && reg_rdata_out[LS_OE]);
	c_delta: cover property ($past(rd_ms) && |reg_rdata_out[3:0]);
	c_loop: cover property ($past(rd_ms) && mcr_q[MC_LOOP] && quiet_q > 4'h3);
endmodule : uls_status_chk

bind uls_line_modem_status uls_status_chk #(.DEPTH(DEPTH)) u_chk (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.baud16_tick_in(baud16_tick_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.rx_serial_in(rx_serial_in), .tx_serial_out(tx_serial_out),
	.clear_to_send_n_in(clear_to_send_n_in),
	.set_ready_n_in(set_ready_n_in), .ring_in_n_in(ring_in_n_in),
	.carrier_detect_n_in(carrier_detect_n_in),
	.request_send_n_out(request_send_n_out),
	.term_ready_n_out(term_ready_n_out), .line_irq_out(line_irq_out),
	.tx_irq_out(tx_irq_out), .modem_irq_out(modem_irq_out));

// >>> test/uls_far_end.sv
`timescale 1ns/1ps
module uls_far_end (
	input  wire logic       clk_in,   // system clock
	input  wire logic       tick_in,  // sixteen times baud tick
	output logic            ser_out,  // serial line, idles high
	output logic      [3:0] ctl_n_out // {carrier, ring, ready, cts}, low
);
	initial begin
		ser_out = 1'b1;
		ctl_n_out = 4'hF;
	end

	// Bits go out least significant first, sixteen ticks each; the line
	// returns to mark afterwards, as a released line with pull-up would.
	task automatic send(input logic [11:0] frame, input int nbits);
		for (int i = 0; i < nbits; i++) begin
			ser_out <= frame[i];
			repeat (16) @(posedge clk_in iff tick_in);
		end
		ser_out <= 1'b1;
	endtask : send

	task automatic set_ctl(input logic [3:0] v);
		ctl_n_out <= v;
	endtask : set_ctl
endmodule : uls_far_end

// >>> test/test_uls_line_modem_status.sv
`timescale 1ns/1ps
module test_uls_line_modem_status;
	import uls_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       tick;
	logic       wr;
	logic       rd;
	logic       ser;
	logic       tx;
	logic       rts_n;
	logic       dtr_n;
	logic       lirq;
	logic       tirq;
	logic       mirq;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] dump;
	logic [3:0] ctl_n;
	logic [7:0] outs;
	logic [7:0] lm [4] = '{8'h12, 8'h11, 8'h14, 8'h18};
	int         bad_count = 0;
	int         n_checks = 0;
	int         cycles = 0;

	assign outs = {2'b00, tx, dtr_n, rts_n, mirq, tirq, lirq};

	uls_line_modem_status #(.DEPTH(4)) dut (
		.sys_clk_in(clk), .rst_n_in(rst_n), .baud16_tick_in(tick),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .rx_serial_in(ser),
		.tx_serial_out(tx), .clear_to_send_n_in(ctl_n[0]),
		.set_ready_n_in(ctl_n[1]), .ring_in_n_in(ctl_n[2]),
		.carrier_detect_n_in(ctl_n[3]), .request_send_n_out(rts_n),
		.term_ready_n_out(dtr_n), .line_irq_out(lirq),
		.tx_irq_out(tirq), .modem_irq_out(mirq));

	uls_far_end far (.clk_in(clk), .tick_in(tick), .ser_out(ser),
		.ctl_n_out(ctl_n));

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		tick <= ~tick;
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// A write lets one edge pass after dropping the strobe.
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg

	task automatic rreg(input logic [2:0] a, output logic [7:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask : rreg

	task automatic xr(input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] d;
		rreg(a, d);
		check(d & m, e);
	endtask : xr

	task automatic look(input logic [7:0] m, input logic [7:0] e);
		#1 check(outs & m, e);
		@(posedge clk);
	endtask : look

	task automatic tx8(input logic [7:0] d, input logic [1:0] tl,
		input int n);
		far.send({1'b1, tl, d, 1'b0}, n);
		repeat (4) @(posedge clk);
	endtask : tx8

	initial begin
		clk = 1'b0;
		tick = 1'b0;
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		xr(OFF_MODEM_STATE, 8'hFF, 8'h00);
		wreg(OFF_LINE_CTL, 8'h03);
		wreg(OFF_IRQ_EN, 8'h0E);
		tx8(8'h55, 2'b11, 10);
		xr(OFF_LINE_STATE, 8'hFF, 8'h61);
		xr(OFF_DATA, 8'hFF, 8'h55);
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		tx8(8'h11, 2'b11, 10);
		tx8(8'h22, 2'b11, 10);
		look(8'h03, 8'h03);
		xr(OFF_LINE_STATE, 8'hFF, 8'h63);
		look(8'h01, 8'h00);
		xr(OFF_LINE_STATE, 8'hFF, 8'h61);
		xr(OFF_DATA, 8'hFF, 8'h22);
		wreg(OFF_LINE_CTL, 8'h1B);
		tx8(8'h01, 2'b10, 11);
		xr(OFF_LINE_STATE, 8'hFF, 8'h65);
		xr(OFF_LINE_STATE, 8'hFF, 8'h61);
		xr(OFF_DATA, 8'hFF, 8'h01);
		// A phantom character may follow the low stop bit, so wait it out.
		wreg(OFF_LINE_CTL, 8'h03);
		tx8(8'hA5, 2'b10, 10);
		repeat (400) @(posedge clk);
		xr(OFF_LINE_STATE, 8'h0D, 8'h09);
		rreg(OFF_DATA, dump);
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		far.send(12'h000, 12);
		repeat (40) @(posedge clk);
		xr(OFF_LINE_STATE, 8'hFF, 8'h79);
		xr(OFF_DATA, 8'hFF, 8'h00);
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		wreg(OFF_DATA, 8'h41);
		wreg(OFF_DATA, 8'h42);
		xr(OFF_LINE_STATE, 8'h60, 8'h00);
		look(8'h02, 8'h00);
		repeat (800) @(posedge clk);
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		far.set_ctl(4'hE);
		repeat (6) @(posedge clk);
		look(8'h04, 8'h04);
		xr(OFF_MODEM_STATE, 8'hFF, 8'h11);
		xr(OFF_MODEM_STATE, 8'hFF, 8'h10);
		far.set_ctl(4'hA);
		repeat (6) @(posedge clk);
		xr(OFF_MODEM_STATE, 8'hFF, 8'h50);
		far.set_ctl(4'hE);
		repeat (6) @(posedge clk);
		xr(OFF_MODEM_STATE, 8'hFF, 8'h14);
		far.set_ctl(4'hF);
		repeat (6) @(posedge clk);
		xr(OFF_MODEM_STATE, 8'hFF, 8'h01);
		wreg(OFF_MODEM_CTL, 8'h1F);
		repeat (4) @(posedge clk);
		look(8'h38, 8'h38);
		for (int i = 0; i < 4; i++) begin
			wreg(OFF_MODEM_CTL, lm[i]);
			repeat (4) @(posedge clk);
			xr(OFF_MODEM_STATE, 8'hF0, 8'h10 << i);
		end
		wreg(OFF_MODEM_CTL, 8'h10);
		wreg(OFF_DATA, 8'h5A);
		repeat (800) @(posedge clk);
		xr(OFF_DATA, 8'hFF, 8'h5A);
		wreg(OFF_MODEM_CTL, 8'h03);
		repeat (4) @(posedge clk);
		look(8'h18, 8'h00);
		wreg(OFF_FIFO_CTL, 8'h01);
		wreg(OFF_LINE_CTL, 8'h1B);
		tx8(8'h01, 2'b10, 11);
		tx8(8'h03, 2'b10, 11);
		xr(OFF_LINE_STATE, 8'hFF, 8'hE5);
		xr(OFF_DATA, 8'hFF, 8'h01);
		xr(OFF_LINE_STATE, 8'hFF, 8'h61);
		xr(OFF_DATA, 8'hFF, 8'h03);
		wreg(OFF_LINE_CTL, 8'h03);
		for (int i = 0; i < 5; i++)
			tx8(8'h30 + 8'(i), 2'b11, 10);
		xr(OFF_LINE_STATE, 8'h03, 8'h03);
		for (int i = 0; i < 4; i++)
			xr(OFF_DATA, 8'hFF, 8'h30 + 8'(i));
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		// Five-bit words: the low stop of the first is the second's start.
		wreg(OFF_LINE_CTL, 8'h00);
		far.send(12'h5AA, 12);
		repeat (40) @(posedge clk);
		xr(OFF_LINE_STATE, 8'h0F, 8'h09);
		xr(OFF_DATA, 8'hFF, 8'h15);
		xr(OFF_DATA, 8'hFF, 8'h0B);
		wreg(OFF_DATA, 8'h41);
		wreg(OFF_DATA, 8'h42);
		xr(OFF_LINE_STATE, 8'h60, 8'h00);
		repeat (800) @(posedge clk);
		xr(OFF_LINE_STATE, 8'hFF, 8'h60);
		wrap_up();
	end
endmodule : test_uls_line_modem_status
